// ==== bench/micro_store_model.sv ====
`timescale 1ns/1ps
module micro_store_model (
  // Address from the sequencer
  input  wire logic [13:0] addr,
  // Word of the addressed location
  output logic      [1:16] word
);
  // Small store; the bench fills it, upper address bits fold onto it.
  // Microcode places alternate targets one below the wanted address.
  logic [1:16] mem [0:63];
  assign word = mem[addr[5:0]];
endmodule

// ==== bench/microprogram_address_sequencer_test.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("ERROR %s exp %h got %h", n, e, g); miscompares++; end end
module microprogram_address_sequencer_test;
  logic clock = 0, sys_rst = 1, system_clock_phase = 0, phase_is_three = 0;
  logic successor_condition = 0, conditional_lu = 0, force_type2 = 0;
  logic hold_sequence = 0, alt_from_micro_store = 0, alt_from_barrel_sel = 0;
  logic [2:0] succ_when_true = 0, succ_when_false = 0;
  logic [1:16] micro_store_word, barrel_switch = 16'h0000;
  logic [13:0] micro_store_addr, micro_pc, alt_micro_pc, next_addr_reg;
  logic phase3_inhibit_n, phase3_strobe, type2_instr, shift_amount_load_en;
  logic literal_load_en, micro_pc_load_en, next_addr_load_en;
  logic alt_from_micro_pc;
  logic [13:0] m, a, i, m_old;
  int miscompares = 0, n_checks = 0;
  always #10 clock = ~clock;
  microprogram_address_sequencer u_microprogram_address_sequencer (.*);
  micro_store_model u_micro_store_model (.addr(micro_store_addr),
    .word(micro_store_word));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [1:16] fill(int k);
    return {4'hF, 12'(k * 37)};
  endfunction
  task strobe(input logic p3);
    @(negedge clock);
    system_clock_phase = 1;
    phase_is_three = p3;
    @(negedge clock);
    system_clock_phase = 0;
  endtask
  task check_regs();
    `CHK("micro_pc", m, micro_pc)
    `CHK("alt_micro_pc", a, alt_micro_pc)
    `CHK("next_addr_reg", i, next_addr_reg)
  endtask
  task do_reset();
    @(negedge clock);
    sys_rst = 1;
    repeat (4) @(negedge clock);
    sys_rst = 0;
    m = 0;
    a = 0;
    i = 0;
    check_regs();
  endtask
  task run_codes();
    for (int c = 0; c < 8; c++) begin
      succ_when_true = 0;
      succ_when_false = 0;
      alt_from_micro_store = 1;
      strobe(0);
      a = u_micro_store_model.mem[i[5:0]][3:16];
      alt_from_micro_store = 0;
      successor_condition = c[0];
      succ_when_true = c[0] ? 3'(c) : 3'(7 - c);
      succ_when_false = c[0] ? 3'(7 - c) : 3'(c);
      #1;
      `CHK("pc_en", 1'(c != 0 && c != 4), micro_pc_load_en)
      `CHK("next_addr_reg_en", 1'(c != 0), next_addr_load_en)
      `CHK("alt_pc", 1'(c == 2 || c == 6), alt_from_micro_pc)
      strobe(0);
      m_old = m;
      case (c)
        1, 2: m = m + 14'h0001;
        3: m = m + 14'h0002;
        5, 6: m = a + 14'h0001;
        7: m = a + 14'h0002;
        default: ;
      endcase
      if (c == 2 || c == 6) a = m_old;
      if (c == 4) i = a + 14'h0001;
      else if (c != 0) i = m;
      check_regs();
    end
  endtask
  task automatic run_type2();
    logic [3:0] ops [3] = '{4'hA, 4'hB, 4'h5};
    logic [1:16] w;
    int idx;
    for (int k = 0; k < 3; k++) begin
      w = {ops[k], 12'h123};
      idx = i[5:0];
      u_micro_store_model.mem[idx] = w;
      succ_when_true = 3'h1;
      succ_when_false = 3'h1;
      #1;
      `CHK("type2", 1'b1, type2_instr)
      `CHK("inhibit", 1'b0, phase3_inhibit_n)
      `CHK("lit_en", ops[k] == 4'hA, literal_load_en)
      `CHK("sar_en", ops[k] == 4'hB, shift_amount_load_en)
      strobe(0);
      m_old = m;
      m = w[3:16] + 14'h0001;
      i = m;
      if (k < 2) a = m_old;
      check_regs();
      u_micro_store_model.mem[idx] = fill(idx);
    end
  endtask
  task run_barrel();
    barrel_switch = 16'hC5A7;
    alt_from_barrel_sel = 1;
    force_type2 = 1;
    strobe(1);
    `CHK("alt_refused", a, alt_micro_pc)
    force_type2 = 0;
    alt_from_barrel_sel = 0;
    conditional_lu = 1;
    successor_condition = 0;
    #1;
    `CHK("cond_inh", 1'b0, phase3_inhibit_n)
    strobe(1);
    `CHK("cond_refused", a, alt_micro_pc)
    successor_condition = 1;
    #1;
    `CHK("cond_met", 1'b1, phase3_inhibit_n)
    strobe(1);
    conditional_lu = 0;
    a = 14'h05A7;
    check_regs();
    barrel_switch = 16'h3A5C;
    alt_from_barrel_sel = 1;
    strobe(1);
    alt_from_barrel_sel = 0;
    a = 14'h3A5C;
    check_regs();
    hold_sequence = 1;
    strobe(0);
    check_regs();
    hold_sequence = 0;
  endtask
  task final_report();
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 64; k++) u_micro_store_model.mem[k] = fill(k);
    do_reset();
    run_codes();
    run_type2();
    run_barrel();
    do_reset();
    run_codes();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    final_report();
  end
endmodule

// ==== bench/sequencer_sva.sv ====
`timescale 1ns/1ps
`include "sequencer_params.svh"
module sequencer_sva #(
  parameter int ADDR_W = 14,
  parameter int WORD_W = 16
) (
  input wire logic clock, sys_rst, system_clock_phase, phase_is_three,
  input wire logic successor_condition, conditional_lu,
  input wire logic alt_from_micro_store, alt_from_barrel_sel,
  input wire logic [1:WORD_W] micro_store_word, barrel_switch,
  input wire logic [ADDR_W-1:0] micro_store_addr, micro_pc,
  input wire logic [ADDR_W-1:0] alt_micro_pc, next_addr_reg,
  input wire logic phase3_inhibit_n, phase3_strobe, type2_instr,
  input wire logic micro_pc_load_en, next_addr_load_en, alt_from_micro_pc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire p1 = system_clock_phase && !phase_is_three;
  a_pc_only_enabled: assert property (!(p1 && micro_pc_load_en) |=>
    $stable(micro_pc)) else $error("micro_pc moved without load");
  a_next_addr_reg_only_enabled: assert property (!(p1 && next_addr_load_en) |=>
    $stable(next_addr_reg)) else $error("next_addr_reg moved");
  a_pc_from_gates: assert property (p1 && micro_pc_load_en &&
    next_addr_load_en |=> micro_pc == next_addr_reg)
    else $error("micro_pc not from select gates");
  a_store_addr_out: assert property (micro_store_addr == next_addr_reg)
    else $error("store address not next_addr_reg");
  a_strobe_gating: assert property (phase3_strobe == (system_clock_phase
    && phase_is_three && phase3_inhibit_n)) else $error("phase 3 strobe");
  a_type2_inhibit: assert property (type2_instr |-> !phase3_inhibit_n)
    else $error("Type II not inhibiting phase 3");
  a_cond_inhibit: assert property (conditional_lu &&
    !successor_condition |-> !phase3_inhibit_n) else $error("cond inhibit");
  a_alt_from_pc: assert property (p1 && alt_from_micro_pc |=>
    alt_micro_pc == $past(micro_pc)) else $error("alt not from micro_pc");
  a_alt_from_store: assert property (p1 && !alt_from_micro_pc &&
    alt_from_micro_store |=> alt_micro_pc == $past(micro_store_word[3:16]))
    else $error("alt not from store field");
  a_alt_from_barrel: assert property (phase3_strobe && alt_from_barrel_sel
    |=> alt_micro_pc == $past(barrel_switch[3:16]))
    else $error("alt not from barrel");
  a_alt_no_strobe: assert property (!system_clock_phase |=>
    $stable(alt_micro_pc)) else $error("alt moved without strobe");
  a_phase3_refused: assert property (system_clock_phase &&
    phase_is_three && !phase3_inhibit_n |=> $stable(alt_micro_pc))
    else $error("alt loaded in inhibited phase 3");
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
    micro_pc == 0 && alt_micro_pc == 0 && next_addr_reg == 0)
    else $error("reset did not clear");
endmodule
bind microprogram_address_sequencer sequencer_sva #(.ADDR_W(ADDR_W),
  .WORD_W(WORD_W)) u_sva (.clock(clock), .sys_rst(sys_rst),
  .system_clock_phase(system_clock_phase), .phase_is_three(phase_is_three),
  .successor_condition(successor_condition),
  .conditional_lu(conditional_lu),
  .alt_from_micro_store(alt_from_micro_store),
  .alt_from_barrel_sel(alt_from_barrel_sel),
  .micro_store_word(micro_store_word), .barrel_switch(barrel_switch),
  .micro_store_addr(micro_store_addr), .micro_pc(micro_pc),
  .alt_micro_pc(alt_micro_pc), .next_addr_reg(next_addr_reg),
  .phase3_inhibit_n(phase3_inhibit_n), .phase3_strobe(phase3_strobe),
  .type2_instr(type2_instr), .micro_pc_load_en(micro_pc_load_en),
  .next_addr_load_en(next_addr_load_en),
  .alt_from_micro_pc(alt_from_micro_pc));

// ==== pkg/sequencer_params.svh ====
`ifndef SEQUENCER_PARAMS_SVH
`define SEQUENCER_PARAMS_SVH
// Notes on behaviour
// - micro_pc holds current address, except execute
// - micro_pc loads only from select gates
// - micro_pc loads on strobe when enabled
// - micro_pc feeds adders and alternate selector
// - 14-bit alternate address register for flow
// - Alternate register doubles as temporary storage
// - Alternate loads from pc, store, barrel
// - Transfer signals pick pc or store field
// - Alternate clocked on strobe by transfer enables
// - Phase 3 suppressed for Type II, unmet condition
// - Phase 3 inhibit is active low
// - Barrel select one loads low barrel bits
// - Barrel load waits for next uninhibited phase 3
// - next_addr_reg holds selected source plus one/two
// - Select lines choose pc or alternate sums
// - next_addr_reg loads on strobe when enabled
// - Adder carries chain across slice boundaries
// - Store address from register, gates feed micro_pc
// - Controls make shift, literal, Type II, inhibit
// - Condition picks one of two successor triples
// - Successor codes set pc, alternate, next address
`define ADDR_W        14
`define SUCC_W        3
`define WORD_W        16
`define SLICE_W       4
`define FIELD_MSB     3
`define FIELD_LSB     16
`define OP_W          4
`define OP_TYPE1      4'hF
`define OP_LIT_LOAD   4'hA
`define OP_SAR_LOAD   4'hB
`define ADDR_RESET    14'h0000
`define ADDR_ONE      14'h0001
`define ADDR_TWO      14'h0002
`endif

// ==== pkg/sequencer_pkg.sv ====
package sequencer_pkg;
  typedef logic [13:0] addr_t;
  typedef enum logic [2:0] {
    SUCC_WAIT = 3'h0,
    SUCC_STEP = 3'h1,
    SUCC_SAVE = 3'h2,
    SUCC_SKIP = 3'h3,
    SUCC_EXECUTE_SUCCESSOR = 3'h4,
    SUCC_JUMP = 3'h5,
    SUCC_CALL = 3'h6,
    SUCC_RETN = 3'h7
  } succ_code_e;
endpackage

// ==== rtl/microprogram_address_sequencer.sv ====
`timescale 1ns/1ps
`include "sequencer_params.svh"
module microprogram_address_sequencer #(
  parameter int ADDR_W = `ADDR_W,
  parameter int WORD_W = `WORD_W
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Phase strobes from the clock generator logic
  input  wire logic              system_clock_phase,
  input  wire logic              phase_is_three,
  // Successor controls from the control store
  input  wire logic [`SUCC_W-1:0] succ_when_true,
  input  wire logic [`SUCC_W-1:0] succ_when_false,
  input  wire logic              successor_condition,
  input  wire logic              conditional_lu,
  input  wire logic              force_type2,
  input  wire logic              hold_sequence,
  // Alternate register steering
  input  wire logic              alt_from_micro_store,
  input  wire logic              alt_from_barrel_sel,
  // Data sources
  input  wire logic [1:WORD_W]   micro_store_word,
  input  wire logic [1:WORD_W]   barrel_switch,
  // Address registers
  output logic [ADDR_W-1:0]      micro_store_addr,
  output logic [ADDR_W-1:0]      micro_pc,
  output logic [ADDR_W-1:0]      alt_micro_pc,
  output logic [ADDR_W-1:0]      next_addr_reg,
  // Sequencer controls
  output logic                   phase3_inhibit_n,
  output logic                   phase3_strobe,
  output logic                   type2_instr,
  output logic                   shift_amount_load_en,
  output logic                   literal_load_en,
  output logic                   micro_pc_load_en,
  output logic                   next_addr_load_en,
  output logic                   alt_from_micro_pc
);

  //////////////////////////////////////////////////////////////////////////
  // Registers and their next values.

  logic [ADDR_W-1:0] micro_pc_r;
  logic [ADDR_W-1:0] micro_pc_nxt;
  logic [ADDR_W-1:0] alt_r;
  logic [ADDR_W-1:0] alt_nxt;
  logic [ADDR_W-1:0] next_addr_r;
  logic [ADDR_W-1:0] next_addr_nxt;
  logic              barrel_pend_r;
  logic              barrel_pend_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Microinstruction format decode.

  logic [`OP_W-1:0]  opcode;
  logic              type2;
  logic              type2_call;
  logic              branch_or_call;
  logic [ADDR_W-1:0] store_field;
  logic [ADDR_W-1:0] barrel_low;

  assign opcode      = micro_store_word[1:`OP_W];
  assign store_field = micro_store_word[`FIELD_MSB:`FIELD_LSB];
  assign barrel_low  = barrel_switch[`FIELD_MSB:`FIELD_LSB];

  // Any format other than the all-ones lead bits is a Type II word.
  assign type2 = (opcode != `OP_TYPE1) | force_type2;

  // Type II call has lead bits 1,0; branch has 0,1.
  assign type2_call = micro_store_word[1] & ~micro_store_word[2]
                      & ~force_type2;
  assign branch_or_call = type2_call | (~micro_store_word[1]
                          & micro_store_word[2] & ~force_type2);

  assign shift_amount_load_en = type2 & (opcode == `OP_SAR_LOAD);
  assign literal_load_en      = type2 & (opcode == `OP_LIT_LOAD);
  assign type2_instr          = type2;

  //////////////////////////////////////////////////////////////////////////
  // Phase 3 inhibit, low while the phase 3 strobe must be withheld.

  logic phase3_inhibit;
  assign phase3_inhibit = type2 | (conditional_lu
                          & ~successor_condition);
  assign phase3_inhibit_n = ~phase3_inhibit;
  assign phase3_strobe = system_clock_phase & phase_is_three
                         & phase3_inhibit_n;

  //////////////////////////////////////////////////////////////////////////
  // Successor decode.

  logic sel_pc_plus_one;
  logic sel_pc_plus_two;
  logic sel_alt_plus_one;
  logic sel_alt_plus_two;
  logic select_store_field;

  successor_decode u_decode (
    .succ_when_true      (succ_when_true),
    .succ_when_false     (succ_when_false),
    .successor_condition (successor_condition),
    .type2               (type2),
    .branch_or_call      (branch_or_call),
    .type2_call          (type2_call),
    .hold_sequence       (hold_sequence),
    .sel_pc_plus_one     (sel_pc_plus_one),
    .sel_pc_plus_two     (sel_pc_plus_two),
    .sel_alt_plus_one    (sel_alt_plus_one),
    .sel_alt_plus_two    (sel_alt_plus_two),
    .micro_pc_load_en    (micro_pc_load_en),
    .next_addr_load_en   (next_addr_load_en),
    .alt_from_micro_pc   (alt_from_micro_pc),
    .select_store_field  (select_store_field)
  );

  //////////////////////////////////////////////////////////////////////////
  // Incrementer adders.

  logic [ADDR_W-1:0] pc_source;
  logic [ADDR_W-1:0] pc_sum1;
  logic [ADDR_W-1:0] pc_sum2;
  logic [ADDR_W-1:0] alt_sum1;
  logic [ADDR_W-1:0] alt_sum2;

  // A Type II branch or call adds to the store field instead of micro_pc.
  assign pc_source = select_store_field ? store_field : micro_pc_r;

  slice_incrementer #(.WIDTH(ADDR_W), .SLICE(`SLICE_W)) u_pc_plus1 (
    .operand (pc_source),
    .add_two (1'b0),
    .sum     (pc_sum1)
  );

  slice_incrementer #(.WIDTH(ADDR_W), .SLICE(`SLICE_W)) u_pc_plus2 (
    .operand (pc_source),
    .add_two (1'b1),
    .sum     (pc_sum2)
  );

  slice_incrementer #(.WIDTH(ADDR_W), .SLICE(`SLICE_W)) u_alt_plus1 (
    .operand (alt_r),
    .add_two (1'b0),
    .sum     (alt_sum1)
  );

  slice_incrementer #(.WIDTH(ADDR_W), .SLICE(`SLICE_W)) u_alt_plus2 (
    .operand (alt_r),
    .add_two (1'b1),
    .sum     (alt_sum2)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next-address select gates, an AND-OR of the four sums.

  logic [ADDR_W-1:0] select_gates;
  assign select_gates = ({ADDR_W{sel_pc_plus_one}}  & pc_sum1)
                      | ({ADDR_W{sel_pc_plus_two}}  & pc_sum2)
                      | ({ADDR_W{sel_alt_plus_one}} & alt_sum1)
                      | ({ADDR_W{sel_alt_plus_two}} & alt_sum2);

  //////////////////////////////////////////////////////////////////////////
  // Load strobes.

  logic phase_one;
  logic seq_strobe;
  logic alt_seq_load;
  logic alt_barrel_load;

  assign phase_one  = system_clock_phase & ~phase_is_three;
  // The sequencing registers advance once per microinstruction.
  assign seq_strobe = phase_one;

  assign alt_seq_load = seq_strobe & (alt_from_micro_pc
                        | alt_from_micro_store);

  // A barrel request survives Type II words and unmet conditions until a phase 3 strobe.
  assign alt_barrel_load = phase3_strobe
                           & (alt_from_barrel_sel | barrel_pend_r);

  //////////////////////////////////////////////////////////////////////////
  // Next values.

  assign micro_pc_nxt = (seq_strobe & micro_pc_load_en) ?
                        select_gates : micro_pc_r;

  assign next_addr_nxt = (seq_strobe & next_addr_load_en) ?
                         select_gates : next_addr_r;

  assign alt_nxt = alt_barrel_load ? barrel_low :
                   !alt_seq_load   ? alt_r :
                   alt_from_micro_pc ? micro_pc_r : store_field;

  assign barrel_pend_nxt = alt_barrel_load ? 1'b0 :
                           (system_clock_phase & alt_from_barrel_sel)
                           ? 1'b1 : barrel_pend_r;

  //////////////////////////////////////////////////////////////////////////
  // State.

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      micro_pc_r    <= `ADDR_RESET;
      alt_r         <= `ADDR_RESET;
      next_addr_r   <= `ADDR_RESET;
      barrel_pend_r <= 1'b0;
    end else begin
      micro_pc_r    <= micro_pc_nxt;
      alt_r         <= alt_nxt;
      next_addr_r   <= next_addr_nxt;
      barrel_pend_r <= barrel_pend_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The store is addressed from the register, never the raw gates.
  assign micro_store_addr = next_addr_r;
  assign micro_pc         = micro_pc_r;
  assign alt_micro_pc     = alt_r;
  assign next_addr_reg    = next_addr_r;

endmodule

// ==== rtl/slice_incrementer.sv ====
`timescale 1ns/1ps
`include "sequencer_params.svh"
module slice_incrementer #(
  parameter int WIDTH = `ADDR_W,
  parameter int SLICE = `SLICE_W
) (
  // Operand and increment
  input  wire logic [WIDTH-1:0] operand,
  input  wire logic             add_two,
  // Sum
  output logic      [WIDTH-1:0] sum
);
  localparam int NSL = (WIDTH + SLICE - 1) / SLICE;
  logic [NSL:0] carry;

  // Carry into the lowest slice is the +1; +2 enters at bit one.
  assign carry[0] = ~add_two;

  genvar s;
  generate
    for (s = 0; s < NSL; s++) begin : g_slice
      localparam int LO = s * SLICE;
      localparam int HI = (LO + SLICE > WIDTH) ? WIDTH - 1 : LO + SLICE - 1;
      localparam int W  = HI - LO + 1;
      logic [W:0]   part;
      logic [W-1:0] addend;
      assign addend = (s == 0) ? W'({add_two, 1'b0}) : '0;
      assign part = {1'b0, operand[HI:LO]} + {1'b0, addend}
                    + {{W{1'b0}}, carry[s]};
      assign sum[HI:LO] = part[W-1:0];
      assign carry[s+1] = part[W];
    end
  endgenerate
endmodule

// ==== rtl/successor_decode.sv ====
`timescale 1ns/1ps
`include "sequencer_params.svh"
module successor_decode (
  // Successor controls
  input  wire logic [`SUCC_W-1:0] succ_when_true,
  input  wire logic [`SUCC_W-1:0] succ_when_false,
  input  wire logic               successor_condition,
  input  wire logic               type2,
  input  wire logic               branch_or_call,
  input  wire logic               type2_call,
  input  wire logic               hold_sequence,
  // Decoded selects and enables
  output logic                    sel_pc_plus_one,
  output logic                    sel_pc_plus_two,
  output logic                    sel_alt_plus_one,
  output logic                    sel_alt_plus_two,
  output logic                    micro_pc_load_en,
  output logic                    next_addr_load_en,
  output logic                    alt_from_micro_pc,
  output logic                    select_store_field
);
  sequencer_pkg::succ_code_e code;
  logic t1;

  assign code = sequencer_pkg::succ_code_e'(successor_condition ?
                succ_when_true : succ_when_false);
  assign t1 = ~type2;

  assign sel_pc_plus_one  = type2 | (t1 &
                            (code == sequencer_pkg::SUCC_STEP |
                             code == sequencer_pkg::SUCC_SAVE));
  assign sel_pc_plus_two  = t1 & (code == sequencer_pkg::SUCC_SKIP);
  assign sel_alt_plus_one = t1 & (code == sequencer_pkg::SUCC_JUMP |
                                  code == sequencer_pkg::SUCC_EXECUTE_SUCCESSOR |
                                  code == sequencer_pkg::SUCC_CALL);
  assign sel_alt_plus_two = t1 & (code == sequencer_pkg::SUCC_RETN);
  assign micro_pc_load_en = ~hold_sequence & (type2 |
                            (code != sequencer_pkg::SUCC_WAIT &
                             code != sequencer_pkg::SUCC_EXECUTE_SUCCESSOR));
  assign next_addr_load_en = ~hold_sequence &
                             (type2 | code != sequencer_pkg::SUCC_WAIT);
  assign alt_from_micro_pc = type2_call | (t1 &
                             (code == sequencer_pkg::SUCC_SAVE |
                              code == sequencer_pkg::SUCC_CALL));
  assign select_store_field = branch_or_call;
endmodule
